// *** core/i2c_irq_cfg.svh ***
`ifndef I2C_IRQ_CFG_SVH
`define I2C_IRQ_CFG_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_CTLW0 6'h00
`define OFS_CTLW1 6'h02
`define OFS_BRW 6'h06
`define OFS_STATW 6'h08
`define OFS_TBCNT 6'h0a
`define OFS_RXBUF 6'h0c
`define OFS_TXBUF 6'h0e
`define OFS_OA0 6'h14
`define OFS_OA1 6'h16
`define OFS_OA2 6'h18
`define OFS_OA3 6'h1a
`define OFS_ADDRX 6'h1c
`define OFS_ADDMASK 6'h1e
`define OFS_I2CSA 6'h20
`define OFS_IE 6'h2a
`define OFS_IFG 6'h2c
`define OFS_IV 6'h2e

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_CTLW0 16'h01c1
`define RST_IFG 16'h2a02
`define RST_ADDMASK 16'h03ff
`define CTLW0_FORCE1 16'h0100
`define CTLW0_FORCE0 16'h1000

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define B_SWRST 0
`define B_TXSTT 1
`define B_MST 11
`define B_ASTP 3:2
`define B_ETX 5
`define B_CLTO 7:6
`define B_BUSY 4
`define B_SCLLOW 6

`define F_RX0 0
`define F_TX0 1
`define F_STT 2
`define F_STP 3
`define F_AL 4
`define F_NACK 5
`define F_BCNT 6
`define F_CLTO 7
`define F_RX1 8
`define F_TX1 9
`define F_RX2 10
`define F_TX2 11
`define F_RX3 12
`define F_TX3 13
`define F_BIT9 14
`define RX_MASK 16'h1501
`define TX_MASK 16'h2a02

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define CLTO_T1_US 28
`define CLTO_T2_US 31
`define CLTO_T3_US 34
`define NS_PER_US 1000

`endif

// *** core/i2c_irq_pkg.sv ***
package i2c_irq_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {
    ASTP_NONE = 2'h0,
    ASTP_COUNT = 2'h1,
    ASTP_AUTO = 2'h2,
    ASTP_SPARE = 2'h3
  } auto_stop_t;
endpackage

// *** core/i2c_irq_flag_vector.sv ***
`timescale 1ns/100ps
`include "i2c_irq_cfg.svh"
// What this block does
// - All sources share one request and vector.
// - Request needs flag, enable and global enable.
// - Receive buffer read clears full flag of last matched address.
// - Transmit-ready zero when buffer can take byte.
// - Slave flags indexed by matched own address.
// - Auto stop: transmit-ready zero threshold times.
// - Buffer write or lost-flag clear drops ready.
// - Ready on start request or address/START.
// - Early transmit: ready zero on START.
// - Receive-full zero on stored character.
// - Soft reset clears receive flags, receive/transmit enables.
// - Arbitration loss: flag, drop master, slave.
// - Master only: flag missing acknowledge.
// - Flag clock held low beyond selection.
// - Ninth-bit flag on data bytes only.
// - Count flag at threshold, mode 01/10.
// - Slave only: START with own address.
// - Flag every STOP on the bus.
// - Vector gives top enabled pending code.
// - Vector read clears top flag only.
// - Vector write clears all flags.
// - Byte counter: START clears, data bytes count.
// - Clock-low flag once per low period.
module i2c_irq_flag_vector #(
  parameter int unsigned CLTO_CYC1 = (`CLTO_T1_US * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int unsigned CLTO_CYC2 = (`CLTO_T2_US * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int unsigned CLTO_CYC3 = (`CLTO_T3_US * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic reg_byte,
  input wire logic global_irq_enable,
  input wire logic scl_in,
  input wire logic start_det,
  input wire logic stop_det,
  input wire logic addr_match,
  input wire logic [1:0] match_idx,
  input wire logic [9:0] rx_address,
  input wire logic addr_phase,
  input wire logic second_bit,
  input wire logic ninth_clk,
  input wire logic rx_byte_done,
  input wire logic [7:0] rx_data,
  input wire logic tx_byte_taken,
  input wire logic arb_lost,
  input wire logic nack_det,
  output logic [15:0] reg_rdata,
  output logic irq_request,
  output logic master_select,
  output logic start_request,
  output logic soft_reset_bit,
  output logic auto_stop_request,
  output logic [7:0] tx_data
);

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    return a[5:1] == ofs[5:1];
  endfunction
  function automatic i2c_irq_pkg::word_t merge(input i2c_irq_pkg::word_t old, input i2c_irq_pkg::word_t wd,
                                               input logic bytew, input logic hi);
    return !bytew ? wd : (hi ? {wd[7:0], old[7:0]} : {old[15:8], wd[7:0]});
  endfunction
  function automatic i2c_irq_pkg::word_t rx_bit(input logic [1:0] idx);
    unique case (idx)
      2'h0: rx_bit = 16'h0001 << `F_RX0;
      2'h1: rx_bit = 16'h0001 << `F_RX1;
      2'h2: rx_bit = 16'h0001 << `F_RX2;
      2'h3: rx_bit = 16'h0001 << `F_RX3;
    endcase
  endfunction
  function automatic i2c_irq_pkg::word_t tx_bit(input logic [1:0] idx);
    return rx_bit(idx) << 1;
  endfunction
  function automatic logic [3:0] prio_bit(input logic [3:0] k);
    unique case (k)
      4'h0: prio_bit = 4'(`F_AL);
      4'h1: prio_bit = 4'(`F_NACK);
      4'h2: prio_bit = 4'(`F_STT);
      4'h3: prio_bit = 4'(`F_STP);
      4'h4: prio_bit = 4'(`F_RX3);
      4'h5: prio_bit = 4'(`F_TX3);
      4'h6: prio_bit = 4'(`F_RX2);
      4'h7: prio_bit = 4'(`F_TX2);
      4'h8: prio_bit = 4'(`F_RX1);
      4'h9: prio_bit = 4'(`F_TX1);
      4'ha: prio_bit = 4'(`F_RX0);
      4'hb: prio_bit = 4'(`F_TX0);
      4'hc: prio_bit = 4'(`F_BCNT);
      4'hd: prio_bit = 4'(`F_CLTO);
      default: prio_bit = 4'(`F_BIT9);
    endcase
  endfunction
  // Scanning from lowest to highest priority lets the highest one win.
  function automatic i2c_irq_pkg::word_t vec_code(input i2c_irq_pkg::word_t pend);
    i2c_irq_pkg::word_t code;
    code = 16'h0000;
    for (int k = 14; k >= 0; k--) begin
      if (pend[prio_bit(4'(k))]) begin
        code = {11'h000, 4'(k + 1), 1'b0};
      end
    end
    return code;
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  i2c_irq_pkg::word_t ctlw0_reg, ctlw1_reg, brw_reg, tbcnt_reg, txbuf_reg, addmask_reg, i2csa_reg;
  i2c_irq_pkg::word_t ie_reg, flags_reg, rdata_reg;
  i2c_irq_pkg::word_t oa_reg [0:3];
  logic [7:0] rxbuf_reg, bcnt_reg;
  logic [9:0] addrx_reg;
  logic [1:0] idx_reg;
  logic busy_reg, irq_reg, auto_stop_reg, scl_s1_reg, scl_s2_reg, scl_s3_reg, scl_low_reg;
  logic [31:0] clto_cnt_reg;

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  logic hi_byte, wr_ctlw0, wr_txbuf, wr_ie, wr_ifg, wr_iv, rd_rxbuf, rd_iv;
  i2c_irq_pkg::word_t ctlw0_wval, status_word, rd_word, rd_out;
  assign hi_byte = reg_addr[0];
  assign wr_ctlw0 = reg_write && hit(reg_addr, `OFS_CTLW0);
  assign wr_txbuf = reg_write && hit(reg_addr, `OFS_TXBUF);
  assign wr_ie = reg_write && hit(reg_addr, `OFS_IE);
  assign wr_ifg = reg_write && hit(reg_addr, `OFS_IFG);
  assign wr_iv = reg_write && hit(reg_addr, `OFS_IV);
  assign rd_rxbuf = reg_read && hit(reg_addr, `OFS_RXBUF);
  assign rd_iv = reg_read && hit(reg_addr, `OFS_IV);
  assign ctlw0_wval = (merge(ctlw0_reg, reg_wdata, reg_byte, hi_byte) | `CTLW0_FORCE1) & ~`CTLW0_FORCE0;
  assign status_word = {bcnt_reg, 1'b0, scl_low_reg, 1'b0, busy_reg, 4'h0};

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  logic master, swrst, etx, auto_done, count_hit;
  i2c_irq_pkg::auto_stop_t astp;
  logic [1:0] clto_sel;
  logic [7:0] bcnt_inc;
  assign master = ctlw0_reg[`B_MST];
  assign swrst = ctlw0_reg[`B_SWRST];
  assign etx = ctlw1_reg[`B_ETX];
  assign astp = i2c_irq_pkg::auto_stop_t'(ctlw1_reg[`B_ASTP]);
  assign clto_sel = ctlw1_reg[`B_CLTO];
  assign auto_done = master && astp == i2c_irq_pkg::ASTP_AUTO && tbcnt_reg != 16'h0000
                     && {8'h00, bcnt_reg} >= tbcnt_reg;
  assign bcnt_inc = bcnt_reg + 8'h01;
  assign count_hit = second_bit && !addr_phase && !start_det && tbcnt_reg != 16'h0000
                     && {8'h00, bcnt_inc} == tbcnt_reg
                     && (astp == i2c_irq_pkg::ASTP_COUNT || astp == i2c_irq_pkg::ASTP_AUTO);

  // ------------------------------------------------------------
  // Clock-low timeout
  // ------------------------------------------------------------
  logic [31:0] clto_limit;
  logic clto_hit;
  assign clto_limit = clto_sel == 2'h1 ? CLTO_CYC1 : (clto_sel == 2'h2 ? CLTO_CYC2 : CLTO_CYC3);
  // The counter saturates at the limit, so one low period flags once.
  assign clto_hit = scl_low_reg && clto_sel != 2'h0 && busy_reg && clto_cnt_reg == clto_limit - 32'h1;

  // ------------------------------------------------------------
  // Flag set and clear
  // ------------------------------------------------------------
  i2c_irq_pkg::word_t pend, iv_now, iv_top, set_vec, clr_vec, base_vec, kept_vec, flags_next;
  logic [1:0] cur_idx;
  logic tx_on_request, al_dropped;
  assign cur_idx = master ? 2'h0 : (addr_match ? match_idx : idx_reg);
  assign pend = flags_reg & ie_reg;
  assign iv_now = vec_code(pend);
  assign iv_top = iv_now == 16'h0000 ? 16'h0000 : 16'h0001 << prio_bit(4'(iv_now[4:1] - 4'h1));
  assign tx_on_request = wr_ctlw0 && ctlw0_wval[`B_TXSTT] && !ctlw0_reg[`B_TXSTT] && ctlw0_wval[`B_MST];
  assign set_vec = (tx_on_request ? tx_bit(2'h0) : 16'h0000)
                 | (addr_match && !master && !etx ? tx_bit(match_idx) : 16'h0000)
                 | (start_det && !master && etx ? tx_bit(2'h0) : 16'h0000)
                 | (tx_byte_taken && !auto_done ? tx_bit(cur_idx) : 16'h0000)
                 | (rx_byte_done ? rx_bit(cur_idx) : 16'h0000)
                 | (16'(arb_lost) << `F_AL)
                 | (16'(nack_det && master) << `F_NACK)
                 | (16'(addr_match && !master) << `F_STT)
                 | (16'(stop_det) << `F_STP)
                 | (16'(count_hit) << `F_BCNT)
                 | (16'(clto_hit) << `F_CLTO)
                 | (16'(ninth_clk && !addr_phase) << `F_BIT9);
  assign clr_vec = (rd_rxbuf ? rx_bit(idx_reg) : 16'h0000)
                 | (wr_txbuf ? `TX_MASK : 16'h0000)
                 | (rd_iv ? iv_top : 16'h0000)
                 | (wr_iv ? 16'hffff : 16'h0000);
  assign base_vec = wr_ifg ? merge(flags_reg, reg_wdata, reg_byte, hi_byte) : flags_reg;
  assign kept_vec = base_vec & ~clr_vec;
  assign al_dropped = flags_reg[`F_AL] && !kept_vec[`F_AL];
  // A new event in the same cycle as a clear survives; soft reset holds receive flags low.
  assign flags_next = ((kept_vec & ~(al_dropped ? `TX_MASK : 16'h0000)) | set_vec)
                      & ~(swrst ? `RX_MASK : 16'h0000);

  // ------------------------------------------------------------
  // Read selection
  // ------------------------------------------------------------
  assign rd_word = hit(reg_addr, `OFS_CTLW0) ? ctlw0_reg :
                   hit(reg_addr, `OFS_CTLW1) ? ctlw1_reg :
                   hit(reg_addr, `OFS_BRW) ? brw_reg :
                   hit(reg_addr, `OFS_STATW) ? status_word :
                   hit(reg_addr, `OFS_TBCNT) ? tbcnt_reg :
                   hit(reg_addr, `OFS_RXBUF) ? {8'h00, rxbuf_reg} :
                   hit(reg_addr, `OFS_TXBUF) ? txbuf_reg :
                   hit(reg_addr, `OFS_OA0) ? oa_reg[0] :
                   hit(reg_addr, `OFS_OA1) ? oa_reg[1] :
                   hit(reg_addr, `OFS_OA2) ? oa_reg[2] :
                   hit(reg_addr, `OFS_OA3) ? oa_reg[3] :
                   hit(reg_addr, `OFS_ADDRX) ? {6'h00, addrx_reg} :
                   hit(reg_addr, `OFS_ADDMASK) ? addmask_reg :
                   hit(reg_addr, `OFS_I2CSA) ? i2csa_reg :
                   hit(reg_addr, `OFS_IE) ? ie_reg :
                   hit(reg_addr, `OFS_IFG) ? flags_reg :
                   hit(reg_addr, `OFS_IV) ? iv_now : 16'h0000;
  assign rd_out = !reg_byte ? rd_word : (hi_byte ? {8'h00, rd_word[15:8]} : {8'h00, rd_word[7:0]});

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctlw0_reg <= `RST_CTLW0;
    end else begin
      if (wr_ctlw0) ctlw0_reg <= ctlw0_wval;
      if (start_det && master) ctlw0_reg[`B_TXSTT] <= 1'b0;
      if (arb_lost) ctlw0_reg[`B_MST] <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctlw1_reg <= 16'h0000;
      brw_reg <= 16'h0000;
      tbcnt_reg <= 16'h0000;
      txbuf_reg <= 16'h0000;
      addmask_reg <= `RST_ADDMASK;
      i2csa_reg <= 16'h0000;
      for (int i = 0; i < 4; i++) begin
        oa_reg[i] <= 16'h0000;
      end
    end else if (reg_write) begin
      if (hit(reg_addr, `OFS_CTLW1)) ctlw1_reg <= merge(ctlw1_reg, reg_wdata, reg_byte, hi_byte);
      if (hit(reg_addr, `OFS_BRW)) brw_reg <= merge(brw_reg, reg_wdata, reg_byte, hi_byte);
      if (hit(reg_addr, `OFS_TBCNT)) tbcnt_reg <= merge(tbcnt_reg, reg_wdata, reg_byte, hi_byte);
      if (wr_txbuf) txbuf_reg <= merge(txbuf_reg, reg_wdata, reg_byte, hi_byte);
      if (hit(reg_addr, `OFS_ADDMASK)) addmask_reg <= merge(addmask_reg, reg_wdata, reg_byte, hi_byte);
      if (hit(reg_addr, `OFS_I2CSA)) i2csa_reg <= merge(i2csa_reg, reg_wdata, reg_byte, hi_byte);
      if (hit(reg_addr, `OFS_OA0)) oa_reg[0] <= merge(oa_reg[0], reg_wdata, reg_byte, hi_byte);
      if (hit(reg_addr, `OFS_OA1)) oa_reg[1] <= merge(oa_reg[1], reg_wdata, reg_byte, hi_byte);
      if (hit(reg_addr, `OFS_OA2)) oa_reg[2] <= merge(oa_reg[2], reg_wdata, reg_byte, hi_byte);
      if (hit(reg_addr, `OFS_OA3)) oa_reg[3] <= merge(oa_reg[3], reg_wdata, reg_byte, hi_byte);
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ie_reg <= 16'h0000;
      flags_reg <= `RST_IFG;
      irq_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      if (swrst) begin
        ie_reg <= ie_reg & ~(`RX_MASK | `TX_MASK);
      end else if (wr_ie) begin
        ie_reg <= merge(ie_reg, reg_wdata, reg_byte, hi_byte);
      end
      flags_reg <= flags_next;
      irq_reg <= global_irq_enable && pend != 16'h0000;
      rdata_reg <= reg_read ? rd_out : 16'h0000;
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bcnt_reg <= 8'h00;
      idx_reg <= 2'h0;
      busy_reg <= 1'b0;
      rxbuf_reg <= 8'h00;
      addrx_reg <= 10'h000;
      auto_stop_reg <= 1'b0;
    end else begin
      if (start_det) begin
        bcnt_reg <= 8'h00;
      end else if (second_bit && !addr_phase) begin
        bcnt_reg <= bcnt_inc;
      end
      if (addr_match) begin
        idx_reg <= match_idx;
        addrx_reg <= rx_address;
      end
      if (start_det) begin
        busy_reg <= 1'b1;
      end else if (stop_det) begin
        busy_reg <= 1'b0;
      end
      if (rx_byte_done) begin
        rxbuf_reg <= rx_data;
      end
      auto_stop_reg <= count_hit && master && astp == i2c_irq_pkg::ASTP_AUTO;
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_s3_reg <= 1'b1;
      scl_low_reg <= 1'b0;
      clto_cnt_reg <= 32'h0;
    end else begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
      if (scl_s2_reg == scl_s3_reg) begin
        scl_low_reg <= !scl_s3_reg;
      end
      if (!scl_low_reg || clto_sel == 2'h0) begin
        clto_cnt_reg <= 32'h0;
      end else if (clto_cnt_reg < clto_limit) begin
        clto_cnt_reg <= clto_cnt_reg + 32'h1;
      end
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq_request = irq_reg;
  assign master_select = ctlw0_reg[`B_MST];
  assign start_request = ctlw0_reg[`B_TXSTT];
  assign soft_reset_bit = ctlw0_reg[`B_SWRST];
  assign auto_stop_request = auto_stop_reg;
  assign tx_data = txbuf_reg[7:0];

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_iv_read_al;
    rd_iv && iv_now == 16'h0002 && !arb_lost && !wr_ifg;
  endsequence
  property p_irq_gate;
    irq_request |-> $past(global_irq_enable) && $past(pend) != 16'h0000;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request without enabled flag");
  property p_rx_read;
    rd_rxbuf && idx_reg == 2'h0 && !rx_byte_done && !wr_ifg |=> !flags_reg[`F_RX0];
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("receive flag not cleared by read");
  property p_tx_write;
    wr_txbuf && (set_vec & `TX_MASK) == 16'h0000 && !wr_ifg |=> (flags_reg & `TX_MASK) == 16'h0000;
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("transmit flags kept after write");
  property p_arb;
    arb_lost |=> !master_select && flags_reg[`F_AL];
  endproperty
  a_arb: assert property (p_arb) else $error("arbitration loss not handled");
  property p_nack_slave;
    nack_det && !master && !flags_reg[`F_NACK] && !wr_ifg |=> !flags_reg[`F_NACK];
  endproperty
  a_nack_slave: assert property (p_nack_slave) else $error("no-ack flag set in slave mode");
  property p_stop;
    stop_det && !swrst |=> flags_reg[`F_STP];
  endproperty
  a_stop: assert property (p_stop) else $error("stop flag missing");
  property p_iv_write;
    wr_iv && set_vec == 16'h0000 |=> flags_reg == 16'h0000;
  endproperty
  a_iv_write: assert property (p_iv_write) else $error("vector write left flags");
  property p_iv_al;
    pend[`F_AL] |-> iv_now == 16'h0002;
  endproperty
  a_iv_al: assert property (p_iv_al) else $error("arbitration vector wrong");
  property p_iv_read;
    s_iv_read_al |=> !flags_reg[`F_AL] ##1 (irq_request == ($past(global_irq_enable) && $past(pend) != 16'h0000));
  endproperty
  a_iv_read: assert property (p_iv_read) else $error("vector read did not clear top flag");
  property p_bit9_addr;
    ninth_clk && addr_phase && !flags_reg[`F_BIT9] && !wr_ifg |=> !flags_reg[`F_BIT9];
  endproperty
  a_bit9_addr: assert property (p_bit9_addr) else $error("ninth-bit flag on address");
  property p_swrst;
    swrst |=> (ie_reg & (`RX_MASK | `TX_MASK)) == 16'h0000 && (flags_reg & `RX_MASK) == 16'h0000;
  endproperty
  a_swrst: assert property (p_swrst) else $error("soft reset left receive state");

endmodule

// *** tb/i2c_bus_partner.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// Far-side bus model
// ------------------------------------------------------------
module i2c_bus_partner (
  input wire logic ref_clk,
  output logic scl_in,
  output logic start_det,
  output logic stop_det,
  output logic addr_match,
  output logic [1:0] match_idx,
  output logic [9:0] rx_address,
  output logic addr_phase,
  output logic second_bit,
  output logic ninth_clk,
  output logic rx_byte_done,
  output logic [7:0] rx_data,
  output logic tx_byte_taken,
  output logic arb_lost,
  output logic nack_det
);
  logic [8:0] ev = 9'h000;
  logic framing = 1'b0;
  logic stretch = 1'b0;
  initial scl_in = 1'b1;
  initial match_idx = 2'h0;
  initial rx_address = 10'h000;
  initial addr_phase = 1'b0;
  initial rx_data = 8'h00;
  assign {nack_det, arb_lost, tx_byte_taken, rx_byte_done, ninth_clk, second_bit, addr_match, stop_det, start_det} = ev;
  // The serial clock runs only inside a frame and can be held low to stretch it.
  always #62.5 scl_in = stretch ? 1'b0 : (framing ? ~scl_in : 1'b1);
  task automatic pulse(input int k, input logic [1:0] idx, input logic [7:0] d, input logic aph);
    @(posedge ref_clk);
    ev <= 9'h001 << k;
    match_idx <= idx;
    rx_data <= d;
    rx_address <= {2'h0, d};
    addr_phase <= aph;
    if (k == 0) framing = 1'b1;
    if (k == 1) framing = 1'b0;
    @(posedge ref_clk);
    ev <= 9'h000;
    rx_data <= ~d;
  endtask
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic reg_byte = 1'b0;
  logic global_irq_enable = 1'b0;
  logic scl_in, start_det, stop_det, addr_match, addr_phase, second_bit, ninth_clk;
  logic rx_byte_done, tx_byte_taken, arb_lost, nack_det;
  logic [1:0] match_idx;
  logic [9:0] rx_address;
  logic [7:0] rx_data, tx_data;
  logic [15:0] reg_rdata;
  logic irq_request, master_select, start_request, soft_reset_bit, auto_stop_request;
  int mismatches = 0;
  int compares = 0;
  always #5 ref_clk = ~ref_clk;
  i2c_bus_partner far (.ref_clk, .scl_in, .start_det, .stop_det, .addr_match, .match_idx, .rx_address,
    .addr_phase, .second_bit, .ninth_clk, .rx_byte_done, .rx_data, .tx_byte_taken, .arb_lost, .nack_det);
  i2c_irq_flag_vector #(.CLTO_CYC1(20), .CLTO_CYC2(30), .CLTO_CYC3(40)) dut (.ref_clk, .resetn, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_byte, .global_irq_enable, .scl_in, .start_det, .stop_det,
    .addr_match, .match_idx, .rx_address, .addr_phase, .second_bit, .ninth_clk, .rx_byte_done, .rx_data,
    .tx_byte_taken, .arb_lost, .nack_det, .reg_rdata, .irq_request, .master_select, .start_request,
    .soft_reset_bit, .auto_stop_request, .tx_data);
  // ------------------------------------------------------------
  // Bus cycles and comparison
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic close_out;
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd(6'h00, 16'h01c1);
    chk(soft_reset_bit, 1'b1);
    reg_byte <= 1'b1;
    rd(6'h01, 16'h0001);
    reg_byte <= 1'b0;
    rd(6'h2c, 16'h2a02);
    wr(6'h2a, 16'h7fff);
    rd(6'h2a, 16'h0000);
    rd(6'h2e, 16'h0000);
    rd(6'h3e, 16'h0000);
  endtask
  task automatic t_drain;
    logic [15:0] v [5] = '{16'h000c, 16'h0010, 16'h0014, 16'h0018, 16'h0000};
    wr(6'h00, 16'h01c0);
    wr(6'h2a, 16'h7fff);
    global_irq_enable <= 1'b1;
    wt(3);
    chk(irq_request, 1'b1);
    foreach (v[i]) rd(6'h2e, v[i]);
    wt(2);
    chk(irq_request, 1'b0);
  endtask
  task automatic t_events;
    far.pulse(1, 2'h0, 8'h00, 1'b0);
    wt(1);
    chk(irq_request, 1'b1);
    global_irq_enable <= 1'b0;
    wt(3);
    chk(irq_request, 1'b0);
    global_irq_enable <= 1'b1;
    rd(6'h2e, 16'h0008);
    far.pulse(5, 2'h0, 8'ha5, 1'b0);
    rd(6'h2c, 16'h0001);
    rd(6'h0c, 16'h00a5);
    rd(6'h2c, 16'h0000);
    far.pulse(4, 2'h0, 8'h00, 1'b1);
    rd(6'h2c, 16'h0000);
    far.pulse(4, 2'h0, 8'h00, 1'b0);
    rd(6'h2e, 16'h001e);
  endtask
  task automatic t_master;
    wr(6'h00, 16'h09c2);
    rd(6'h2c, 16'h0002);
    wr(6'h0e, 16'h005a);
    chk(tx_data, 8'h5a);
    rd(6'h2c, 16'h0000);
    chk(master_select, 1'b1);
    far.pulse(8, 2'h0, 8'h00, 1'b0);
    far.pulse(7, 2'h0, 8'h00, 1'b0);
    wt(1);
    chk(master_select, 1'b0);
    rd(6'h2e, 16'h0002);
    rd(6'h2e, 16'h0004);
    far.pulse(8, 2'h0, 8'h00, 1'b0);
    far.pulse(6, 2'h0, 8'h00, 1'b0);
    rd(6'h2c, 16'h0002);
    wr(6'h2e, 16'h0000);
    rd(6'h2c, 16'h0000);
  endtask
  task automatic t_slave;
    far.pulse(0, 2'h0, 8'h00, 1'b1);
    far.pulse(2, 2'h2, 8'h12, 1'b1);
    rd(6'h2c, 16'h0804);
    wr(6'h0e, 16'h0033);
    rd(6'h2c, 16'h0004);
    rd(6'h2e, 16'h0006);
    far.pulse(1, 2'h0, 8'h00, 1'b0);
    rd(6'h2e, 16'h0008);
    wr(6'h02, 16'h0024);
    wr(6'h0a, 16'h0002);
    far.pulse(0, 2'h0, 8'h00, 1'b1);
    rd(6'h2c, 16'h0002);
    far.pulse(3, 2'h0, 8'h00, 1'b0);
    far.pulse(3, 2'h0, 8'h00, 1'b0);
    rd(6'h2c, 16'h0042);
    reg_byte <= 1'b1;
    rd(6'h09, 16'h0002);
    reg_byte <= 1'b0;
    far.pulse(1, 2'h0, 8'h00, 1'b0);
    wr(6'h2e, 16'h0000);
  endtask
  task automatic t_timeout;
    wr(6'h02, 16'h0040);
    far.pulse(0, 2'h0, 8'h00, 1'b1);
    far.stretch = 1'b1;
    wt(100);
    rd(6'h2c, 16'h0080);
    rd(6'h2e, 16'h001c);
    wt(100);
    rd(6'h2c, 16'h0000);
    far.stretch = 1'b0;
    far.pulse(1, 2'h0, 8'h00, 1'b0);
  endtask
  task automatic t_auto;
    wr(6'h2e, 16'h0000);
    wr(6'h02, 16'h0008);
    wr(6'h0a, 16'h0002);
    wr(6'h00, 16'h09c0);
    wr(6'h00, 16'h09c2);
    chk(start_request, 1'b1);
    far.pulse(0, 2'h0, 8'h00, 1'b0);
    #1 chk(start_request, 1'b0);
    rd(6'h2c, 16'h0002);
    wr(6'h0e, 16'h0001);
    far.pulse(3, 2'h0, 8'h00, 1'b0);
    far.pulse(6, 2'h0, 8'h00, 1'b0);
    rd(6'h2c, 16'h0002);
    wr(6'h0e, 16'h0002);
    far.pulse(3, 2'h0, 8'h00, 1'b0);
    #1 chk(auto_stop_request, 1'b1);
    far.pulse(6, 2'h0, 8'h00, 1'b0);
    rd(6'h2c, 16'h0040);
    far.pulse(1, 2'h0, 8'h00, 1'b0);
    wr(6'h2e, 16'h0000);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset;
    t_drain;
    t_events;
    t_master;
    t_slave;
    t_timeout;
    t_auto;
    close_out;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    close_out;
  end
endmodule
